// ===== mfp_pkg.sv
// mfp_pkg: constants, register map and carrier types of the meter front-panel control
package mfp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 125000;                       // hclk rate in kHz
  localparam int DEBOUNCE_MS = 10;                       // settle time of a key contact
  localparam int LONG_PRESS_MS = 1000;                   // least hold time of a long press
  localparam int BLINK_HALF_MS = 500;                    // half period of the teach blink
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // keys and digits
  // ----------------------------------------------------------------
  localparam int NUM_KEYS = 5;
  localparam int KEY_MAXMIN = 0;
  localparam int KEY_LEVEL = 1;
  localparam int KEY_MODE = 2;
  localparam int KEY_SHIFT = 3;
  localparam int KEY_UP = 4;
  localparam int NUM_DIGITS = 5;                         // five decimal digits per value
  localparam int VALUE_W = 4 * NUM_DIGITS;
  localparam int PARAM_COUNT = 4;                        // parameters per setting level

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMP1 = 8'h08;
  localparam logic [7:0] OFS_CMP2 = 8'h0c;
  localparam logic [7:0] OFS_RANGE = 8'h10;
  localparam logic [7:0] OFS_DEPEND = 8'h14;

  // control field positions
  localparam int CTRL_LOCK_BIT = 0;                      // setting-change lockout
  localparam int CTRL_KPROT_BIT = 1;                     // key protection of set values
  localparam int CTRL_TAVAIL_BIT = 2;                    // teaching available
  localparam int CTRL_TBUSY_BIT = 3;                     // teaching in progress
  localparam int CTRL_W = 4;

  // status field positions
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_DISP_LSB = 4;
  localparam int ST_EDIT_BIT = 10;
  localparam int ST_DIGIT_LSB = 11;
  localparam int ST_FZERO_BIT = 14;
  localparam int ST_RUN_BIT = 15;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [VALUE_W-1:0] CMP_RESET = 20'h00000;
  localparam logic RANGE_RESET = 1'b1;                   // fast pulse range
  localparam logic [VALUE_W-1:0] DEPEND_DEF_FAST = 20'h00000;
  localparam logic [VALUE_W-1:0] DEPEND_DEF_SLOW = 20'h00002;

  // level indicator glyphs, segments gfedcba
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_P = 7'h73;
  localparam logic [6:0] SEG_5 = 7'h6d;
  localparam logic [6:0] SEG_F = 7'h71;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LVL_PROTECT = 4'h1,
    LVL_OPERATION = 4'h2,
    LVL_INITIAL = 4'h4,
    LVL_ADVANCED = 4'h8
  } mfp_level_t;

  typedef enum logic [5:0] {
    DISP_MEAS = 6'h01,
    DISP_MAX = 6'h02,
    DISP_MIN = 6'h04,
    DISP_CMP1 = 6'h08,
    DISP_CMP2 = 6'h10,
    DISP_PARAM = 6'h20
  } mfp_disp_t;

  typedef struct packed {
    logic held;                                          // debounced level
    logic press;                                         // pulse on debounced press
    logic short_rel;                                     // pulse on release before long
    logic long_hit;                                      // pulse when the hold reaches long
  } mfp_key_evt_t;

endpackage

// ===== mfp_key.sv
// mfp_key: debounce and press-duration timing of one front-panel key
`timescale 1ns/1ns
module mfp_key #(
  parameter int DEBOUNCE_CYC = mfp_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = mfp_pkg::LONG_PRESS_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic key_raw,
  output mfp_pkg::mfp_key_evt_t evt
);

  localparam int DW = $clog2(DEBOUNCE_CYC + 1);
  localparam int LW = $clog2(LONG_CYC + 1);

  generate
    if (DEBOUNCE_CYC < 1 || LONG_CYC < 2) begin : g_bad
      $error("mfp_key: debounce must be at least 1 and long press at least 2 cycles");
    end
  endgenerate

  logic stable;
  logic long_seen;
  logic [DW-1:0] db_cnt;
  logic [LW-1:0] hold_cnt;

  // ----------------------------------------------------------------
  // debounce: the raw level must differ for a full settle time
  // ----------------------------------------------------------------
  wire differ = key_raw != stable;
  wire db_done = differ && (db_cnt == DW'(DEBOUNCE_CYC - 1));
  wire hold_top = hold_cnt == LW'(LONG_CYC - 1);
  wire long_hit = stable && hold_top && !long_seen;

  // settle counter restarts on any bounce back to the stable level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      db_cnt <= '0;
      stable <= 1'b0;
    end else begin
      db_cnt <= (differ && !db_done) ? db_cnt + DW'(1) : '0;
      stable <= db_done ? key_raw : stable;
    end
  end

  // hold counter saturates so a very long press fires only once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt <= '0;
      long_seen <= 1'b0;
    end else begin
      hold_cnt <= !stable ? '0 : (hold_top ? hold_cnt : hold_cnt + LW'(1));
      long_seen <= stable && (long_seen || long_hit);
    end
  end

  // press, short release and long events are one-cycle pulses; held is the debounced level
  assign evt.held = stable;
  assign evt.press = db_done && key_raw;
  assign evt.short_rel = db_done && !key_raw && !long_seen;
  assign evt.long_hit = long_hit;

endmodule

// ===== mfp_panel.sv
// mfp_panel: front-panel key handling, level and display control with an AHB-Lite register file
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module mfp_panel #(
  parameter int DEBOUNCE_CYC = mfp_pkg::DEBOUNCE_CYC,
  parameter int LONG_CYC = mfp_pkg::LONG_PRESS_CYC,
  parameter int BLINK_CYC = mfp_pkg::BLINK_HALF_CYC,
  parameter int PARAM_COUNT = mfp_pkg::PARAM_COUNT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [mfp_pkg::NUM_KEYS-1:0] key_in,
  input wire logic compare_output_one,
  input wire logic compare_output_two,
  output logic lamp_compare_output_one,
  output logic lamp_compare_output_two,
  output logic set_value_lamp,
  output logic max_lamp,
  output logic min_lamp,
  output logic teach_lamp,
  output logic [6:0] level_segments,
  output logic [5:0] display_sel,
  output logic edit_active,
  output logic [2:0] edit_digit,
  output logic measure_run,
  output logic force_zero,
  output logic maxmin_clear
);

  localparam int BW = $clog2(BLINK_CYC + 1);
  localparam int PW = (PARAM_COUNT > 1) ? $clog2(PARAM_COUNT) : 1;
  generate
    if (BLINK_CYC < 1 || PARAM_COUNT < 2 || PARAM_COUNT > 16) begin : g_bad
      $error("mfp_panel: blink must be at least 1 cycle and parameter count 2 to 16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // key conditioning
  // ----------------------------------------------------------------
  mfp_pkg::mfp_key_evt_t evt [mfp_pkg::NUM_KEYS];
  // one debouncer and press timer per key
  for (genvar k = 0; k < mfp_pkg::NUM_KEYS; k++) begin : g_key
    mfp_key #(
      .DEBOUNCE_CYC(DEBOUNCE_CYC),
      .LONG_CYC(LONG_CYC)
    ) u_key (
      .hclk(hclk),
      .hresetn(hresetn),
      .key_raw(key_in[k]),
      .evt(evt[k])
    );
  end

  wire mm_short = evt[mfp_pkg::KEY_MAXMIN].short_rel;
  wire mm_long = evt[mfp_pkg::KEY_MAXMIN].long_hit;
  wire lvl_short = evt[mfp_pkg::KEY_LEVEL].short_rel;
  wire mode_short = evt[mfp_pkg::KEY_MODE].short_rel;
  wire shift_short = evt[mfp_pkg::KEY_SHIFT].short_rel;
  wire up_short = evt[mfp_pkg::KEY_UP].short_rel;
  wire lvl_held = evt[mfp_pkg::KEY_LEVEL].held;
  wire mode_held = evt[mfp_pkg::KEY_MODE].held;
  // the first long hold reached while the other key is held fires the combination once
  logic combo_done;
  wire combo_raw = (evt[mfp_pkg::KEY_LEVEL].long_hit && mode_held) ||
                   (evt[mfp_pkg::KEY_MODE].long_hit && lvl_held);
  wire combo_fire = combo_raw && !combo_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      combo_done <= 1'b0;
    end else begin
      combo_done <= (lvl_held || mode_held) && (combo_done || combo_fire);
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mfp_pkg::mfp_level_t level;
  mfp_pkg::mfp_level_t next_level;
  mfp_pkg::mfp_disp_t disp;
  mfp_pkg::mfp_disp_t next_disp;
  logic [PW-1:0] param_idx;
  logic [PW-1:0] next_param_idx;
  logic next_edit;
  logic [2:0] next_digit;
  logic [mfp_pkg::CTRL_W-1:0] ctrl;
  logic [mfp_pkg::VALUE_W-1:0] cmp1;
  logic [mfp_pkg::VALUE_W-1:0] cmp2;
  logic range_sel;
  logic [mfp_pkg::VALUE_W-1:0] depend;
  wire setting_lock = ctrl[mfp_pkg::CTRL_LOCK_BIT];
  wire key_protect = ctrl[mfp_pkg::CTRL_KPROT_BIT];
  wire in_oper = level == mfp_pkg::LVL_OPERATION;
  wire in_prot = level == mfp_pkg::LVL_PROTECT;
  wire in_init = level == mfp_pkg::LVL_INITIAL;
  wire on_meas = disp == mfp_pkg::DISP_MEAS;
  wire on_mm = (disp == mfp_pkg::DISP_MAX) || (disp == mfp_pkg::DISP_MIN);
  wire on_cmp = (disp == mfp_pkg::DISP_CMP1) || (disp == mfp_pkg::DISP_CMP2);
  wire on_param = disp == mfp_pkg::DISP_PARAM;
  wire last_param = param_idx == PW'(PARAM_COUNT - 1);

  // ----------------------------------------------------------------
  // edit target decode
  // ----------------------------------------------------------------
  // protect parameters stay editable under the lockout, all others do not
  wire tgt_cmp1 = in_oper && disp == mfp_pkg::DISP_CMP1 && !key_protect;
  wire tgt_cmp2 = in_oper && disp == mfp_pkg::DISP_CMP2 && !key_protect;
  wire tgt_range = in_init && on_param && param_idx == PW'(0);
  wire tgt_depend = in_init && on_param && param_idx == PW'(1);
  wire tgt_lock = in_prot && on_param && param_idx == PW'(0);
  wire tgt_kprot = in_prot && on_param && param_idx == PW'(1);
  wire lock_ok = !setting_lock || in_prot;
  wire tgt_any = lock_ok &&
                 (tgt_cmp1 || tgt_cmp2 || tgt_range || tgt_depend || tgt_lock || tgt_kprot);

  // the up key edits only while editing; outside editing, up on the operation-level measurement display is the forced-zero toggle
  wire edit_up = edit_active && up_short && tgt_any;
  wire fz_toggle = in_oper && on_meas && !edit_active && up_short;

  // one decimal digit of a five digit value, counted up with wrap at nine
  function automatic logic [mfp_pkg::VALUE_W-1:0] bump_digit(
    input logic [mfp_pkg::VALUE_W-1:0] val,
    input logic [2:0] pos
  );
    logic [mfp_pkg::VALUE_W-1:0] res;
    logic [3:0] dig;
    res = val;
    dig = val[4*pos +: 4];
    res[4*pos +: 4] = (dig >= 4'h9) ? 4'h0 : dig + 4'h1;
    return res;
  endfunction
  // ----------------------------------------------------------------
  // level and display state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_level = level;
    next_disp = disp;
    next_param_idx = param_idx;
    next_edit = edit_active;
    next_digit = edit_digit;
    if (combo_fire) begin
      next_edit = 1'b0;
      next_param_idx = '0;
      unique case (level)
        mfp_pkg::LVL_OPERATION: begin
          next_level = mfp_pkg::LVL_PROTECT;
          next_disp = mfp_pkg::DISP_PARAM;
        end
        mfp_pkg::LVL_PROTECT: begin
          next_level = mfp_pkg::LVL_OPERATION;
          next_disp = mfp_pkg::DISP_MEAS;
        end
        mfp_pkg::LVL_INITIAL: begin
          next_level = mfp_pkg::LVL_ADVANCED;
          next_disp = mfp_pkg::DISP_PARAM;
        end
        mfp_pkg::LVL_ADVANCED: begin
          next_level = mfp_pkg::LVL_INITIAL;
          next_disp = mfp_pkg::DISP_PARAM;
        end
        default: begin
          next_level = mfp_pkg::LVL_OPERATION;
          next_disp = mfp_pkg::DISP_MEAS;
        end
      endcase
    end else if (lvl_short && (in_oper || in_init)) begin
      next_edit = 1'b0;
      next_param_idx = '0;
      next_level = in_oper ? mfp_pkg::LVL_INITIAL : mfp_pkg::LVL_OPERATION;
      next_disp = in_oper ? mfp_pkg::DISP_PARAM : mfp_pkg::DISP_MEAS;
    end else if (mode_short) begin
      next_edit = 1'b0;
      if (in_oper) begin
        if (on_meas || on_mm) begin
          next_disp = mfp_pkg::DISP_CMP1;
        end else if (disp == mfp_pkg::DISP_CMP1) begin
          next_disp = mfp_pkg::DISP_CMP2;
        end else begin
          next_disp = mfp_pkg::DISP_MEAS;
        end
      end else begin
        next_param_idx = last_param ? '0 : param_idx + PW'(1);
      end
    end else if (mm_short && in_oper && !edit_active) begin
      if (on_meas) begin
        next_disp = mfp_pkg::DISP_MAX;
      end else if (disp == mfp_pkg::DISP_MAX) begin
        next_disp = mfp_pkg::DISP_MIN;
      end else if (disp == mfp_pkg::DISP_MIN) begin
        next_disp = mfp_pkg::DISP_MEAS;
      end
    end else if (shift_short && tgt_any) begin
      next_edit = 1'b1;
      next_digit = (!edit_active || edit_digit == 3'(mfp_pkg::NUM_DIGITS - 1)) ?
                   3'h0 : edit_digit + 3'h1;
    end
  end

  // held state of the level machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= mfp_pkg::LVL_OPERATION;
      disp <= mfp_pkg::DISP_MEAS;
      param_idx <= '0;
      edit_active <= 1'b0;
      edit_digit <= 3'h0;
    end else begin
      level <= next_level;
      disp <= next_disp;
      param_idx <= next_param_idx;
      edit_active <= next_edit;
      edit_digit <= next_digit;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  wire take = hsel && hready && htrans[1];
  wire bus_wr = wr_pend;
  wire wr_ctrl = bus_wr && wr_addr == mfp_pkg::OFS_CTRL;
  wire wr_cmp1 = bus_wr && wr_addr == mfp_pkg::OFS_CMP1;
  wire wr_cmp2 = bus_wr && wr_addr == mfp_pkg::OFS_CMP2;
  wire wr_range = bus_wr && wr_addr == mfp_pkg::OFS_RANGE;
  wire wr_depend = bus_wr && wr_addr == mfp_pkg::OFS_DEPEND;
  wire [31:0] status_word = {16'h0000, measure_run, force_zero, edit_digit, edit_active,
                             display_sel, level};
  wire [31:0] rd_word =
    (haddr[7:0] == mfp_pkg::OFS_CTRL) ? {28'h0000000, ctrl} :
    (haddr[7:0] == mfp_pkg::OFS_STATUS) ? status_word :
    (haddr[7:0] == mfp_pkg::OFS_CMP1) ? {12'h000, cmp1} :
    (haddr[7:0] == mfp_pkg::OFS_CMP2) ? {12'h000, cmp2} :
    (haddr[7:0] == mfp_pkg::OFS_RANGE) ? {31'h00000000, range_sel} :
    (haddr[7:0] == mfp_pkg::OFS_DEPEND) ? {12'h000, depend} : 32'h00000000;
  wire mapped = haddr[31:8] == 24'h000000;
  // address phase is latched; read data is registered into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= take && hwrite && mapped;
      wr_addr <= haddr[7:0];
      hrdata <= (take && !hwrite && mapped) ? rd_word : 32'h00000000;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // settings: bus writes win over a key edit in the same cycle; a range change reloads the dependent default over both
  // ----------------------------------------------------------------
  wire next_range = wr_range ? hwdata[0] :
                    (edit_up && tgt_range) ? !range_sel : range_sel;
  wire range_change = next_range != range_sel;
  wire [mfp_pkg::VALUE_W-1:0] depend_def = next_range ? mfp_pkg::DEPEND_DEF_FAST :
                                                        mfp_pkg::DEPEND_DEF_SLOW;
  wire [mfp_pkg::CTRL_W-1:0] ctrl_keyed = {ctrl[3:2],
    ctrl[mfp_pkg::CTRL_KPROT_BIT] ^ (edit_up && tgt_kprot),
    ctrl[mfp_pkg::CTRL_LOCK_BIT] ^ (edit_up && tgt_lock)};
  // set values and settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= mfp_pkg::CTRL_RESET;
      cmp1 <= mfp_pkg::CMP_RESET;
      cmp2 <= mfp_pkg::CMP_RESET;
      range_sel <= mfp_pkg::RANGE_RESET;
      depend <= mfp_pkg::DEPEND_DEF_FAST;
    end else begin
      ctrl <= wr_ctrl ? hwdata[mfp_pkg::CTRL_W-1:0] : ctrl_keyed;
      cmp1 <= wr_cmp1 ? hwdata[mfp_pkg::VALUE_W-1:0] :
              (edit_up && tgt_cmp1) ? bump_digit(cmp1, edit_digit) : cmp1;
      cmp2 <= wr_cmp2 ? hwdata[mfp_pkg::VALUE_W-1:0] :
              (edit_up && tgt_cmp2) ? bump_digit(cmp2, edit_digit) : cmp2;
      range_sel <= next_range;
      depend <= range_change ? depend_def :
                wr_depend ? hwdata[mfp_pkg::VALUE_W-1:0] :
                (edit_up && tgt_depend) ? bump_digit(depend, edit_digit) : depend;
    end
  end

  // ----------------------------------------------------------------
  // teach blink timer
  // ----------------------------------------------------------------
  logic [BW-1:0] blink_cnt;
  logic blink_phase;
  wire blink_top = blink_cnt == BW'(BLINK_CYC - 1);
  // free running so every blink has equal halves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else begin
      blink_cnt <= blink_top ? '0 : blink_cnt + BW'(1);
      blink_phase <= blink_phase ^ blink_top;
    end
  end

  // ----------------------------------------------------------------
  // lamps and indicators, one cycle behind their causes, except display_sel, which is disp itself
  // ----------------------------------------------------------------
  wire [6:0] seg_sel = in_prot ? mfp_pkg::SEG_P :
                       in_oper ? mfp_pkg::SEG_BLANK :
                       in_init ? mfp_pkg::SEG_5 : mfp_pkg::SEG_F;
  wire teach_on = ctrl[mfp_pkg::CTRL_TAVAIL_BIT] &&
                  (!ctrl[mfp_pkg::CTRL_TBUSY_BIT] || blink_phase);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_compare_output_one <= 1'b0;
      lamp_compare_output_two <= 1'b0;
      set_value_lamp <= 1'b0;
      max_lamp <= 1'b0;
      min_lamp <= 1'b0;
      teach_lamp <= 1'b0;
      level_segments <= mfp_pkg::SEG_BLANK;
      measure_run <= 1'b1;
      force_zero <= 1'b0;
      maxmin_clear <= 1'b0;
    end else begin
      lamp_compare_output_one <= compare_output_one;
      lamp_compare_output_two <= compare_output_two;
      set_value_lamp <= (in_oper && on_cmp) || edit_active;
      max_lamp <= disp == mfp_pkg::DISP_MAX;
      min_lamp <= disp == mfp_pkg::DISP_MIN;
      teach_lamp <= teach_on;
      level_segments <= seg_sel;
      measure_run <= in_prot || in_oper;
      force_zero <= force_zero ^ fz_toggle;
      maxmin_clear <= mm_long && in_oper && on_mm;
    end
  end
  assign display_sel = disp;
endmodule

// ===== mfp_keys_model.sv
// mfp_keys_model: operator pressing front-panel keys, with contact chatter at each press
`timescale 1ns/1ns
module mfp_keys_model (
  input wire logic hclk,
  input wire logic go,
  input wire logic [4:0] mask,
  input wire logic [15:0] hold,
  output logic [4:0] key_in
);
  logic [15:0] cnt = 16'h0;
  // four chatter cycles, then a steady hold, then release
  always_ff @(posedge hclk) begin
    if (go) cnt <= hold + 16'h4;
    else if (cnt != 16'h0) cnt <= cnt - 16'h1;
  end
  // chatter is shorter than the debounce span, so it must not count as presses
  assign key_in = (cnt != 16'h0 && (cnt <= hold || cnt[0])) ? mask : 5'h00;
endmodule

// ===== mfp_panel_checker.sv
// mfp_panel_checker: port-level assertions on the front-panel control
`timescale 1ns/1ns
module mfp_panel_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic compare_output_one,
  input wire logic compare_output_two,
  input wire logic lamp_compare_output_one,
  input wire logic lamp_compare_output_two,
  input wire logic max_lamp,
  input wire logic min_lamp,
  input wire logic [6:0] level_segments,
  input wire logic [5:0] display_sel,
  input wire logic [2:0] edit_digit,
  input wire logic force_zero,
  input wire logic maxmin_clear
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence clr_pulse; maxmin_clear ##1 !maxmin_clear; endsequence
  lamp_one_a: assert property (lamp_compare_output_one == $past(compare_output_one))
    else $error("lamp one does not follow output one");
  lamp_two_a: assert property (lamp_compare_output_two == $past(compare_output_two))
    else $error("lamp two does not follow output two");
  max_lamp_a: assert property (max_lamp == ($past(display_sel) == mfp_pkg::DISP_MAX))
    else $error("max lamp wrong");
  min_lamp_a: assert property (min_lamp == ($past(display_sel) == mfp_pkg::DISP_MIN))
    else $error("min lamp wrong");
  clear_pulse_a: assert property ($rose(maxmin_clear) |-> clr_pulse)
    else $error("clear pulse longer than one cycle");
  clear_where_a: assert property (maxmin_clear |-> display_sel[2:1] != 2'h0)
    else $error("clear outside max or min display");
  digit_range_a: assert property (edit_digit <= 3'h4)
    else $error("edit digit out of range");
  zero_source_a: assert property ($changed(force_zero) |-> $past(display_sel) == 6'h01)
    else $error("forced zero changed away from measurement");
  level_glyph_a: assert property (level_segments inside {7'h73, 7'h00, 7'h6d, 7'h71})
    else $error("level indicator shows no level glyph");
endmodule
bind mfp_panel mfp_panel_checker u_mfp_panel_checker (.hclk, .hresetn, .compare_output_one,
  .compare_output_two, .lamp_compare_output_one, .lamp_compare_output_two, .max_lamp, .min_lamp, .level_segments,
  .display_sel, .edit_digit, .force_zero, .maxmin_clear);

// ===== mfp_panel_bench.sv
// mfp_panel_bench: self-checking bench of the front-panel control
`timescale 1ns/1ns
module mfp_panel_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, seen;
  logic compare_output_one = 0, compare_output_two = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, edit_digit;
  logic [4:0] mask = 0, key_in;
  logic [15:0] hold = 0;
  logic hreadyout, hresp, lamp_compare_output_one, lamp_compare_output_two, set_value_lamp, max_lamp, min_lamp;
  logic edit_active, measure_run, force_zero, maxmin_clear, teach_lamp;
  logic [6:0] level_segments;
  logic [5:0] display_sel;
  int n_fail = 0, checks = 0;
  initial forever #4 hclk = ~hclk;
  // short counts keep long presses affordable
  mfp_panel #(.DEBOUNCE_CYC(4), .LONG_CYC(40), .BLINK_CYC(8), .PARAM_COUNT(4)) u_mfp_panel (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .key_in, .compare_output_one, .compare_output_two, .lamp_compare_output_one,
    .lamp_compare_output_two, .set_value_lamp, .max_lamp, .min_lamp, .teach_lamp, .level_segments,
    .display_sel, .edit_active, .edit_digit, .measure_run, .force_zero, .maxmin_clear);
  mfp_keys_model u_mfp_keys_model (.hclk, .go, .mask, .hold, .key_in);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single AHB transfer; waits on hready in both phases
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // press, release, then allow debounce plus the state and lamp cycles
  task press(input logic [4:0] m, input logic [15:0] h);
    @(posedge hclk);
    mask <= m;
    hold <= h;
    go <= 1;
    @(posedge hclk);
    go <= 0;
    seen = 0;
    repeat (h + 16) begin
      @(posedge hclk);
      seen |= maxmin_clear;
    end
  endtask
  task t_lamps;
    compare_output_one <= 1;
    repeat (3) @(posedge hclk);
    chk("lamp one", 1, lamp_compare_output_one);
    chk("lamp two", 0, lamp_compare_output_two);
    compare_output_one <= 0;
    compare_output_two <= 1;
    repeat (3) @(posedge hclk);
    chk("lamp one off", 0, lamp_compare_output_one);
    chk("lamp two on", 1, lamp_compare_output_two);
    compare_output_two <= 0;
    $display("t_lamps done");
  endtask
  task t_maxmin;
    press(5'h01, 10);
    chk("display max", mfp_pkg::DISP_MAX, display_sel);
    press(5'h01, 10);
    chk("min lamp", 1, min_lamp);
    press(5'h01, 60);
    chk("clear pulse", 1, seen);
    press(5'h01, 10);
    chk("display meas", mfp_pkg::DISP_MEAS, display_sel);
    $display("t_maxmin done");
  endtask
  task t_edit;
    press(5'h04, 10);
    press(5'h04, 10);
    chk("set value lamp", 1, set_value_lamp);
    press(5'h08, 10);
    press(5'h08, 10);
    chk("edit digit", 1, edit_digit);
    press(5'h10, 10);
    bus(0, 8'h0c, 0);
    chk("second value", 32'h10, rd);
    press(5'h04, 10);
    chk("edit left", 0, edit_active);
    press(5'h10, 10);
    chk("forced zero", 1, force_zero);
    $display("t_edit done");
  endtask
  task t_level;
    press(5'h02, 10);
    chk("initial glyph", mfp_pkg::SEG_5, level_segments);
    chk("halted", 0, measure_run);
    bus(1, 8'h10, 0);
    bus(0, 8'h14, 0);
    chk("dependent default", 32'h2, rd);
    bus(0, 8'h40, 0);
    chk("unmapped read", 0, rd);
    press(5'h02, 10);
    press(5'h06, 60);
    chk("protect glyph", mfp_pkg::SEG_P, level_segments);
    chk("running", 1, measure_run);
    $display("t_level done");
  endtask
  // steady lamp when teaching is available, equal halves of blink while it runs
  task t_teach;
    bus(1, 8'h00, 32'h4);
    repeat (3) @(posedge hclk);
    chk("teach steady", 1, teach_lamp);
    bus(1, 8'h00, 32'hc);
    repeat (2) @(posedge hclk);
    rd = 0;
    repeat (16) begin
      @(posedge hclk);
      rd = rd + teach_lamp;
    end
    chk("teach blink", 8, rd);
    bus(1, 8'h00, 32'h0);
    $display("t_teach done");
  endtask
  // lockout set from protect level, then refused on a comparison value
  task t_lock;
    press(5'h08, 10);
    press(5'h10, 10);
    bus(0, 8'h00, 0);
    chk("protect edit", 1, rd);
    press(5'h06, 60);
    press(5'h04, 10);
    press(5'h08, 10);
    chk("edit refused", 0, edit_active);
    press(5'h10, 10);
    bus(0, 8'h08, 0);
    chk("value kept", 0, rd);
    $display("t_lock done");
  endtask
  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    t_lamps;
    t_teach;
    t_maxmin;
    t_edit;
    t_level;
    t_lock;
    complete_run;
  end
  // the tests need about 770 cycles
  initial begin
    repeat (6000) @(posedge hclk);
    n_fail++;
    complete_run;
  end
endmodule
